// File: udr_top.v
// usb device register slice: enable mask ports, endpoint enable and frame number.
// assumes an apb master on pclk and a protocol engine on the same clock.
//
// Contract
// - one on clear port clears mask bit
// - one on set port sets mask bit
// - zero bits leave mask bits unchanged
// - clear and set ports share one layout
// - only endpoints 0 to 6 implemented
// - disabled endpoint ignores all usb requests
// - disabling resets endpoint regs, keeps configuration
// - writing one enables; read shows state
// - error flag bit 15, frame bits 13:3
// - frame number from last frame start
// - error flag follows frame start, bus reset
// - mask bit gates its interrupt source
`timescale 1ns/10ps
`include "udr_regs.vh"

module udr_top #(
    parameter NUM_EP = 7
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [31:0] irq_source,
    input wire sof_event,
    input wire sof_crc_error,
    input wire [10:0] sof_frame,
    input wire bus_reset,
    input wire ep_req_valid,
    input wire [3:0] ep_req_num,
    output wire ep_req_accept,
    output wire ep_req_ignore,
    output wire [NUM_EP-1:0] endpoint_enable_bit,
    output wire [NUM_EP-1:0] ep_regs_reset,
    output wire usb_irq
);
    // ==========================================================
    // bus slave state; answer sequencer states are one-hot
    localparam [1:0] ST_IDLE = 2'h1;
    localparam [1:0] ST_ANSWER = 2'h2;
    reg [31:0] prdata_ff;
    reg [31:0] nxt_prdata;
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg pslverr_ff;
    reg nxt_pslverr;
    wire setup_phase;
    wire access_done;
    wire wr_en;
    wire [11:0] word_addr;
    wire addr_hit;
    wire answering;

    // ==========================================================
    // block state
    localparam [NUM_EP-1:0] EP_RESET = `UDR_RST_EP_ENABLE;
    wire [NUM_EP-1:0] ep_en_bits;
    wire [NUM_EP-1:0] ep_rst_bits;
    wire [31:0] irq_gated;
    reg accept_ff;
    reg ignore_ff;
    reg irq_ff;
    wire [31:0] mask;
    wire [10:0] frame_number;
    wire frame_number_error_flag;
    wire [31:0] frame_view;
    wire clr_we;
    wire set_we;
    wire ep_we;
    wire [31:0] wmask;
    wire [31:0] wdata_eff;
    wire [NUM_EP-1:0] ep_wbits;
    wire req_in_range;
    wire req_enabled;

    // ==========================================================
    // apb phase decode; the slave answers in the first access cycle
    assign setup_phase = psel && !penable;
    assign answering = state_ff[1]; // one-hot bit of the answer state
    assign access_done = psel && penable && answering;
    assign wr_en = access_done && pwrite;
    assign word_addr = paddr[11:0];
    assign addr_hit = (paddr[31:12] == 20'h00000) && (paddr[1:0] == 2'b00);

    // byte strobes gate which lanes of a write count
    assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    assign wdata_eff = pwdata & wmask;

    // write strobes per register
    assign clr_we = wr_en && addr_hit && (word_addr == `UDR_OFF_EN_CLR);
    assign set_we = wr_en && addr_hit && (word_addr == `UDR_OFF_EN_SET);
    assign ep_we = wr_en && addr_hit && (word_addr == `UDR_OFF_EP_ENABLE);

    // ==========================================================
    // read mux and error decode, evaluated during the setup cycle
    always @* begin
        nxt_prdata = 32'h00000000;
        nxt_pslverr = 1'b0;
        if (!addr_hit) begin
            nxt_pslverr = 1'b1;
        end else begin
            case (word_addr)
                `UDR_OFF_MASK_VIEW: begin
                    nxt_prdata = mask;
                end
                `UDR_OFF_EN_CLR: begin
                    nxt_prdata = `UDR_WO_READ;
                end
                `UDR_OFF_EN_SET: begin
                    nxt_prdata = `UDR_WO_READ;
                end
                `UDR_OFF_EP_ENABLE: begin
                    nxt_prdata = {{(32-NUM_EP){1'b0}}, ep_en_bits};
                end
                `UDR_OFF_FRAME_NUM: begin
                    nxt_prdata = frame_view;
                end
                default: begin
                    nxt_pslverr = 1'b1;
                end
            endcase
        end
        if (pwrite) begin
            nxt_prdata = 32'h00000000;
        end
    end

    // ==========================================================
    // answer sequencer: a setup cycle moves to the answer state, which lasts
    // exactly one access cycle, so the slave never inserts wait states
    always @* begin
        nxt_state = ST_IDLE;
        case (state_ff)
            ST_IDLE: begin
                if (setup_phase) begin
                    nxt_state = ST_ANSWER;
                end
            end
            ST_ANSWER: begin
                // one access cycle only; a setup right behind it starts over
                nxt_state = ST_IDLE;
            end
            default: begin
                // an illegal code falls back to idle instead of hanging the bus
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // state register; reset lands in idle with pready low
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ==========================================================
    // answer data: latched on the setup edge, standing only while pready is
    // high and zero otherwise, so a stale word never shows on the bus
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end else if (setup_phase) begin
            prdata_ff <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end else begin
            prdata_ff <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end
    end

    // ==========================================================
    // frame number view: flag at 15, high part 13:8, low part 7:3
    assign frame_view[31:16] = 16'h0000;
    assign frame_view[`UDR_FN_ERR_BIT] = frame_number_error_flag;
    assign frame_view[14] = 1'b0;
    assign frame_view[`UDR_FN_HI_MSB:`UDR_FN_HI_LSB] = frame_number[10:5];
    assign frame_view[`UDR_FN_LO_MSB:`UDR_FN_LO_LSB] = frame_number[4:0];
    assign frame_view[2:0] = 3'b000;

    // ==========================================================
    // enable mask: clear and set ports both land on the same bit layout
    udr_mask_reg u_mask (
        .pclk(pclk),
        .presetn(presetn),
        .clr_we(clr_we),
        .set_we(set_we),
        .wdata(wdata_eff),
        .mask(mask)
    );

    // ==========================================================
    // frame number capture from the protocol engine
    udr_frame_capture u_frame (
        .pclk(pclk),
        .presetn(presetn),
        .sof_event(sof_event),
        .sof_crc_error(sof_crc_error),
        .sof_frame(sof_frame),
        .bus_reset(bus_reset),
        .frame_number(frame_number),
        .frame_number_error_flag(frame_number_error_flag)
    );

    // ==========================================================
    // endpoint enable: one enable flop and one reset-pulse flop per endpoint;
    // only endpoints 0..6 exist, so higher written bits are dropped
    assign ep_wbits = wdata_eff[NUM_EP-1:0];

    genvar n;
    generate
        for (n = 0; n < NUM_EP; n = n + 1) begin : g_ep
            reg en_ff;
            reg rst_ff;
            reg nxt_en;
            reg nxt_rst;

            // a write replaces the enable; a zero also pulses the reset,
            // even for an endpoint that already was disabled
            always @* begin
                nxt_en = en_ff;
                nxt_rst = 1'b0;
                if (ep_we) begin
                    nxt_en = ep_wbits[n];
                    // the engine clears status and control but keeps the bank
                    // count, bank size, direction and transfer type
                    nxt_rst = !ep_wbits[n];
                end
            end

            // enable level and one-cycle reset pulse
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    en_ff <= EP_RESET[n];
                    rst_ff <= 1'b0;
                end else begin
                    en_ff <= nxt_en;
                    rst_ff <= nxt_rst;
                end
            end

            assign ep_en_bits[n] = en_ff;
            assign ep_rst_bits[n] = rst_ff;
        end
    endgenerate

    // ==========================================================
    // request filter: requests to disabled or absent endpoints are ignored;
    // the range test guards numbers 7..15, which have no enable flop
    assign req_in_range = (ep_req_num < NUM_EP);
    assign req_enabled = req_in_range && ep_en_bits[ep_req_num[2:0]];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accept_ff <= 1'b0;
            ignore_ff <= 1'b0;
        end else begin
            accept_ff <= ep_req_valid && req_enabled;
            ignore_ff <= ep_req_valid && !req_enabled;
        end
    end

    // ==========================================================
    // interrupt gating: each source passes only when its mask bit is one;
    // unimplemented mask bits read zero, so their sources never fire
    genvar s;
    generate
        for (s = 0; s < 32; s = s + 1) begin : g_src
            assign irq_gated[s] = irq_source[s] && mask[s];
        end
    endgenerate

    // interrupt line, registered so it comes straight from a flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |irq_gated;
        end
    end

    // ==========================================================
    // outputs straight from flops
    assign prdata = prdata_ff;
    assign pready = state_ff[1]; // one-hot bit of the answer state
    assign pslverr = pslverr_ff;
    assign ep_req_accept = accept_ff;
    assign ep_req_ignore = ignore_ff;
    assign endpoint_enable_bit = ep_en_bits;
    assign ep_regs_reset = ep_rst_bits;
    assign usb_irq = irq_ff;
endmodule // udr_top

// File: udr_regs.vh
// register offsets, field positions and reset values of the usb device
// enable-mask, endpoint-enable and frame-number registers.
// assumes a 32-bit apb slave with byte addresses and word-aligned registers.
`ifndef UDR_REGS_VH
`define UDR_REGS_VH

// ==========================================================
// register byte offsets
`define UDR_OFF_MASK_VIEW 12'h010
`define UDR_OFF_EN_CLR 12'h014
`define UDR_OFF_EN_SET 12'h018
`define UDR_OFF_EP_ENABLE 12'h01c
`define UDR_OFF_FRAME_NUM 12'h020
`define UDR_ADDR_W 12

// ==========================================================
// enable mask bit positions (shared by clear and set ports)
`define UDR_BIT_SUSPEND 0
`define UDR_BIT_FRAME_START 2
`define UDR_BIT_BUS_RESET_END 3
`define UDR_BIT_WAKE 4
`define UDR_BIT_RESUME_END 5
`define UDR_BIT_UPSTREAM_RESUME 6
`define UDR_BIT_EP_BASE 12
`define UDR_MASK_IMPL 32'h0007f07d

// ==========================================================
// frame number register layout
`define UDR_FN_ERR_BIT 15
`define UDR_FN_HI_MSB 13
`define UDR_FN_HI_LSB 8
`define UDR_FN_LO_MSB 7
`define UDR_FN_LO_LSB 3
`define UDR_FN_WIDTH 11

// ==========================================================
// reset values
`define UDR_RST_MASK 32'h00000000
`define UDR_RST_EP_ENABLE 7'h00
`define UDR_RST_FRAME_NUM 11'h000
`define UDR_WO_READ 32'h00000000

`endif

// File: udr_mask_reg.v
// global interrupt-enable mask with write-one-to-clear and write-one-to-set ports.
// assumes clr_we and set_we are single-cycle strobes from the bus slave.
`timescale 1ns/10ps
`include "udr_regs.vh"

module udr_mask_reg (
    input wire pclk,
    input wire presetn,
    input wire clr_we,
    input wire set_we,
    input wire [31:0] wdata,
    output wire [31:0] mask
);
    localparam [31:0] IMPL_BITS = `UDR_MASK_IMPL;
    localparam [31:0] RST_BITS = `UDR_RST_MASK;
    wire [31:0] mask_bits;

    // ==========================================================
    // one flop per implemented bit; unimplemented bits are tied to zero
    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1) begin : g_bit
            if (IMPL_BITS[i]) begin : g_impl
                reg bit_ff;
                // clear and set never coincide: they are separate bus writes
                always @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        bit_ff <= RST_BITS[i];
                    end else if (clr_we && wdata[i]) begin
                        bit_ff <= 1'b0;
                    end else if (set_we && wdata[i]) begin
                        bit_ff <= 1'b1;
                    end
                end
                assign mask_bits[i] = bit_ff;
            end else begin : g_none
                assign mask_bits[i] = 1'b0;
            end
        end
    endgenerate

    // zero bits in either port leave the mask alone
    assign mask = mask_bits;
endmodule // udr_mask_reg

// File: udr_frame_capture.v
// frame number and frame-number error flag captured from start-of-frame packets.
// assumes sof_event and bus_reset are one-cycle pulses from the protocol engine on pclk.
`timescale 1ns/10ps
`include "udr_regs.vh"

module udr_frame_capture (
    input wire pclk,
    input wire presetn,
    input wire sof_event,
    input wire sof_crc_error,
    input wire [10:0] sof_frame,
    input wire bus_reset,
    output wire [10:0] frame_number,
    output wire frame_number_error_flag
);
    reg [10:0] frame_ff;
    reg err_ff;

    // ==========================================================
    // bus reset wins over a frame arriving in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_ff <= `UDR_RST_FRAME_NUM;
            err_ff <= 1'b0;
        end else if (bus_reset) begin
            frame_ff <= `UDR_RST_FRAME_NUM;
            err_ff <= 1'b0;
        end else if (sof_event) begin
            frame_ff <= sof_frame;
            err_ff <= sof_crc_error;
        end
    end

    assign frame_number = frame_ff;
    assign frame_number_error_flag = err_ff;
endmodule // udr_frame_capture

// File: udr_top_end_marker_unused.v
// holds no logic: the block is udr_top, with udr_mask_reg and
// udr_frame_capture beside it.

// File: udr_top_checker.sv
// checker for the usb device register slice: endpoints, requests, reads, irq.
// assumes it is bound to udr_top and sees only its ports.
`timescale 1ns/10ps

module udr_top_checker #(parameter NUM_EP = 7) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire [31:0] prdata,
    input wire pready,
    input wire [31:0] irq_source,
    input wire ep_req_valid,
    input wire [3:0] ep_req_num,
    input wire ep_req_accept,
    input wire ep_req_ignore,
    input wire [NUM_EP-1:0] endpoint_enable_bit,
    input wire [NUM_EP-1:0] ep_regs_reset,
    input wire usb_irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========
    // decoded bus events
    wire acc = psel && penable && pready;
    wire wr_ep = acc && pwrite && paddr == 32'h1c;
    wire [NUM_EP-1:0] ep_val = pwdata[NUM_EP-1:0] & {NUM_EP{pstrb[0]}};
    wire hit = ep_req_num < NUM_EP && endpoint_enable_bit[ep_req_num[2:0]];
    // ==========
    // assertions
    ep_write_a: assert property (wr_ep |=> endpoint_enable_bit == $past(ep_val))
        else $error("endpoint enables differ from written value");
    ep_flush_a: assert property (wr_ep |=> ep_regs_reset == ~$past(ep_val))
        else $error("endpoint register reset pulses wrong");
    ep_hold_a: assert property (!wr_ep |=> $stable(endpoint_enable_bit))
        else $error("endpoint enables moved without a write");
    ep_accept_a: assert property (ep_req_valid && hit |=> ep_req_accept && !ep_req_ignore)
        else $error("request to enabled endpoint not accepted");
    ep_ignore_a: assert property (ep_req_valid && !hit |=> ep_req_ignore && !ep_req_accept)
        else $error("request to disabled endpoint not ignored");
    wo_read_a: assert property (acc && !pwrite && (paddr == 32'h14 || paddr == 32'h18)
        |-> prdata == 32'h0)
        else $error("write-only port read nonzero");
    fn_layout_a: assert property (acc && !pwrite && paddr == 32'h20
        |-> prdata[31:16] == 16'h0 && !prdata[14] && prdata[2:0] == 3'h0)
        else $error("frame word has bits outside its fields");
    irq_quiet_a: assert property (irq_source == 32'h0 |=> !usb_irq)
        else $error("interrupt without a source");
    ep_reset_a: assert property ($rose(presetn) |-> endpoint_enable_bit == '0)
        else $error("endpoint enables not cleared by reset");
    // main scenarios
    cover property (wr_ep);
    cover property (ep_req_valid && hit);
    cover property (acc && paddr == 32'h20);
endmodule // udr_top_checker

bind udr_top udr_top_checker #(.NUM_EP(NUM_EP)) udr_top_checker_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .irq_source(irq_source), .ep_req_valid(ep_req_valid), .ep_req_num(ep_req_num),
    .ep_req_accept(ep_req_accept), .ep_req_ignore(ep_req_ignore),
    .endpoint_enable_bit(endpoint_enable_bit), .ep_regs_reset(ep_regs_reset),
    .usb_irq(usb_irq));

// File: udr_engine_model.sv
// usb engine stand-in: frame starts, bus resets, endpoint requests, irq flags.
// assumes callers enter its tasks right after a rising edge of pclk.
`timescale 1ns/10ps

module udr_engine_model (
    input wire pclk,
    output logic sof_event,
    output logic sof_crc_error,
    output logic [10:0] sof_frame,
    output logic bus_reset,
    output logic ep_req_valid,
    output logic [3:0] ep_req_num,
    output logic [31:0] irq_source
);
    // idle state; qualifiers flip after a pulse so stale values never match
    initial begin
        sof_event = 1'b0;
        sof_crc_error = 1'b0;
        sof_frame = 11'h0;
        bus_reset = 1'b0;
        ep_req_valid = 1'b0;
        ep_req_num = 4'h0;
        irq_source = 32'h0;
    end
    task automatic sof(input logic [10:0] f, input logic e);
        sof_event <= 1'b1;
        sof_frame <= f;
        sof_crc_error <= e;
        @(posedge pclk);
        sof_event <= 1'b0;
        sof_frame <= ~f;
        sof_crc_error <= ~e;
    endtask
    task automatic usb_reset();
        bus_reset <= 1'b1;
        @(posedge pclk);
        bus_reset <= 1'b0;
    endtask
    task automatic req(input logic [3:0] n);
        ep_req_valid <= 1'b1;
        ep_req_num <= n;
        @(posedge pclk);
        ep_req_valid <= 1'b0;
        ep_req_num <= ~n;
    endtask
    task automatic set_irq(input logic [31:0] v);
        irq_source <= v;
        @(posedge pclk);
    endtask
endmodule // udr_engine_model

// File: udr_top_test.sv
// self-checking bench for udr_top with an apb master and the engine model.
// assumes 100 MHz pclk and the hand-over timing of udr_top.
`timescale 1ns/10ps

module udr_top_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, irq_source;
    logic [3:0] pstrb = 4'hf, ep_req_num;
    logic pready, pslverr, sof_event, sof_crc_error, bus_reset, ep_req_valid;
    logic ep_req_accept, ep_req_ignore, usb_irq;
    logic [10:0] sof_frame;
    logic [6:0] endpoint_enable_bit, ep_regs_reset;
    logic [31:0] rnd = 32'hf, m = 32'h0, rd, d;
    int mismatches = 0, checked = 0, cycles = 0, i;

    always #5 pclk = ~pclk;
    udr_top udr_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq_source(irq_source),
        .sof_event(sof_event), .sof_crc_error(sof_crc_error), .sof_frame(sof_frame),
        .bus_reset(bus_reset), .ep_req_valid(ep_req_valid), .ep_req_num(ep_req_num),
        .ep_req_accept(ep_req_accept), .ep_req_ignore(ep_req_ignore),
        .endpoint_enable_bit(endpoint_enable_bit), .ep_regs_reset(ep_regs_reset),
        .usb_irq(usb_irq));
    udr_engine_model udr_engine_model_inst (.pclk(pclk), .sof_event(sof_event),
        .sof_crc_error(sof_crc_error), .sof_frame(sof_frame), .bus_reset(bus_reset),
        .ep_req_valid(ep_req_valid), .ep_req_num(ep_req_num), .irq_source(irq_source));

    // ==========
    // helpers
    function automatic logic [31:0] roll();
        rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
        return rnd;
    endfunction
    function automatic logic [31:0] fn_word(input logic [10:0] f, input logic e);
        return {16'h0, e, 1'b0, f, 3'h0};
    endfunction
    function automatic logic [31:0] lanes(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one apb transfer: setup, then access until pready is seen high at a
    // rising edge; data and error are taken at that edge, then released
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {20'h0, a};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(rd, x);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // hang guard
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            close_out();
        end
    end

    // ==========
    // main sequence
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(12'h010, 32'h0);
        rdc(12'h01c, 32'h0);
        rdc(12'h014, 32'h0);
        rdc(12'h018, 32'h0);
        $display("reset test done");
        d = 32'hffffffff;
        for (i = 0; i < 8; i++) begin
            apb(1'b1, 12'h018, d);
            m = m | (d & 32'h0007f07d);
            rdc(12'h010, m);
            d = roll();
            pstrb <= d[3:0];
            apb(1'b1, 12'h014, roll());
            pstrb <= 4'hf;
            m = m & ~(rnd & lanes(d[3:0]));
            rdc(12'h010, m);
            udr_engine_model_inst.set_irq(roll());
            @(negedge pclk);
            chk(usb_irq, |(irq_source & m));
            @(posedge pclk);
            d = roll();
        end
        $display("mask test done");
        for (i = 0; i < 4; i++) begin
            d = (i == 0) ? 32'h1ff : (i == 3) ? 32'h0 : roll();
            apb(1'b1, 12'h01c, d);
            rdc(12'h01c, d & 32'h7f);
            for (int n = 0; n < 16; n++) begin
                udr_engine_model_inst.req(n[3:0]);
                @(negedge pclk);
                chk(ep_req_accept, n < 7 && d[n]);
                chk(ep_req_ignore, !(n < 7 && d[n]));
                @(posedge pclk);
            end
        end
        $display("endpoint test done");
        for (i = 0; i < 6; i++) begin
            d = roll();
            udr_engine_model_inst.sof(d[10:0], d[11]);
            rdc(12'h020, fn_word(d[10:0], d[11]));
        end
        udr_engine_model_inst.usb_reset();
        rdc(12'h020, 32'h0);
        apb(1'b0, 12'h024, 32'h0);
        chk(er, 1'b1);
        $display("frame test done");
        close_out();
    end
endmodule // udr_top_test
